// ### rcaa_pkg.sv
// Package for the radio channel access arbiter: encodings, timing, table.
// Assumes a 20 MHz system clock.
package rcaa_pkg;
    localparam int unsigned CLK_HZ        = 20000000;
    localparam int unsigned AIR_BPS       = 9600;
    // Air bit period in cycles, rounded down
    localparam int unsigned AIR_DIV       = CLK_HZ / AIR_BPS;
    localparam int unsigned AIR_DIV_W     = 12;
    // Terminal pause: three characters of ten bits at the configured baud
    localparam int unsigned PAUSE_CHARS   = 3;
    localparam int unsigned CHAR_BITS     = 10;
    localparam int unsigned PAUSE_W       = 24;
    // Buffer depth in bytes
    localparam int unsigned BUF_DEPTH     = 64;
    localparam int unsigned BUF_AW        = 6;
    // Power level codes 0..6 map to +7,+10,+13,+17,+20,+24,+27 dBm
    localparam logic [2:0]  PWR_MAX_STD   = 3'h4;
    localparam logic [2:0]  PWR_MAX_HIGH  = 3'h6;
    // Threshold and RSSI in dBm, signed 8 bit
    localparam logic [7:0]  THRESH_RESET  = 8'h8F; // -113
    localparam logic [7:0]  RSSI_MIN      = 8'h8D; // -115
    localparam logic [7:0]  RSSI_MAX      = 8'hD8; // -40
    localparam logic        TXPRIO_RESET  = 1'b1;
    typedef enum logic [1:0] {
        RCAA_IDLE = 2'b00,
        RCAA_RX   = 2'b01,
        RCAA_WAIT = 2'b10,
        RCAA_TX   = 2'b11
    } rcaa_state_t;
endpackage : rcaa_pkg

// ### rcaa_buf_if.sv
// Carrier between the arbiter and its byte buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface rcaa_buf_if;
    logic       wr_valid;
    logic       wr_ready;
    logic [7:0] wr_data;
    logic       rd_valid;
    logic       rd_ready;
    logic [7:0] rd_data;
    logic       flush;
    logic       empty;
    modport buf_side (input wr_valid, wr_data, rd_ready, flush,
                      output wr_ready, rd_valid, rd_data, empty);
    modport user_side (output wr_valid, wr_data, rd_ready, flush,
                       input wr_ready, rd_valid, rd_data, empty);
endinterface : rcaa_buf_if
`default_nettype wire

// ### rcaa_fifo.sv
// Byte FIFO holding terminal data until the air link takes it.
// Assumes synchronous use from a single clock; read data is registered.
`timescale 1ns/1ns
`default_nettype none
module rcaa_fifo
    import rcaa_pkg::*;
(
    input  wire logic   i_sys_clk,
    input  wire logic   i_rst_n,
    rcaa_buf_if.buf_side bus
);
    logic [7:0]      mem [BUF_DEPTH];
    logic [BUF_AW:0] wp;
    logic [BUF_AW:0] rp;
    logic            rd_full;
    logic [7:0]      rd_data;
    logic            full;
    logic            wr_go;
    logic            pop;
    logic [BUF_AW:0] occ;

    assign full   = (wp[BUF_AW] != rp[BUF_AW]) &&
                    (wp[BUF_AW-1:0] == rp[BUF_AW-1:0]);
    assign wr_go  = bus.wr_valid && !full;
    // Output register is refilled when empty or being taken
    assign pop    = (wp != rp) && (!rd_full || bus.rd_ready);
    assign bus.wr_ready = !full;
    assign bus.rd_valid = rd_full;
    assign bus.rd_data  = rd_data;
    assign bus.empty    = (wp == rp) && !rd_full;
    // Bytes held in the array, modulo twice the depth
    assign occ          = wp - rp;

    always_ff @(posedge i_sys_clk) begin
        if (wr_go) begin
            mem[wp[BUF_AW-1:0]] <= bus.wr_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp <= '0;
            rp <= '0;
        end else if (bus.flush) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (wr_go) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_full <= 1'b0;
            rd_data <= 8'h00;
        end else if (bus.flush) begin
            rd_full <= 1'b0;
        end else if (pop) begin
            rd_full <= 1'b1;
            rd_data <= mem[rp[BUF_AW-1:0]];
        end else if (bus.rd_ready) begin
            rd_full <= 1'b0;
        end
    end

    property p_no_overrun;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        occ <= (BUF_AW+1)'(BUF_DEPTH);
    endproperty
    a_no_overrun: assert property (p_no_overrun)
        else $error("buffer holds more than its depth");
endmodule : rcaa_fifo
`default_nettype wire

// ### rcaa_arbiter.sv
// Radio channel access arbiter: buffers terminal bytes, decides when the
// radio transmits or receives, and serialises bytes at the air bit rate.
// Assumes a UART in front delivers bytes and a radio front end behind.
//
// How it works
// - Air bits leave at a fixed 9600 bps regardless of terminal baud.
// - Terminal bytes exceeding air throughput wait in a byte buffer.
// - Power code 0..6 is +7..+27 dBm; top two need the high model.
// - Data search runs only while RSSI exceeds the threshold.
// - RSSI voltage code maps by table to -115..-40 dBm.
// - Transmit priority resets to enabled.
// - With priority on, transmitter keys as soon as terminal data shows.
// - With priority on, terminal data aborts a reception in progress.
// - With priority off, transmit waits for a free channel, data buffered.
// - Transmission ends on empty buffer plus three-character pause.
`timescale 1ns/1ns
`default_nettype none
module rcaa_arbiter
    import rcaa_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_term_data,
    input  wire logic       i_term_valid,
    output logic            o_term_ready,
    input  wire logic [15:0] i_term_bit_cycles,
    input  wire logic       i_txprio_toggle,
    input  wire logic       i_high_power_model,
    input  wire logic [2:0] i_power_code,
    input  wire logic [7:0] i_threshold,
    input  wire logic       i_threshold_load,
    input  wire logic [3:0] i_rssi_volt,
    input  wire logic       i_rx_sync,
    input  wire logic       i_rx_done,
    output logic            o_tx_on,
    output logic            o_tx_bit,
    output logic            o_rx_search,
    output logic            o_rx_abort,
    output logic [2:0]      o_power_code,
    output logic [7:0]      o_rssi_dbm,
    output logic            o_carrier_present_indicator,
    output logic            o_txprio,
    output logic [1:0]      o_state
);
    rcaa_buf_if  bufc ();
    rcaa_state_t state;
    rcaa_state_t next_state;
    logic [AIR_DIV_W-1:0] div_cnt;
    logic        air_tick;
    logic        txprio;
    logic [7:0]  threshold;
    logic [7:0]  rssi;
    logic        above;
    logic        busy;
    logic [PAUSE_W-1:0] idle_cnt;
    logic [PAUSE_W-1:0] pause_len;
    logic        pause_seen;
    logic [3:0]  bit_idx;
    logic [9:0]  shreg;
    logic        shifting;
    logic        tx_end;
    logic [7:0]  rssi_tab [16];

    rcaa_fifo u_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .bus       (bufc.buf_side)
    );

    // Fixed air bit rate divider
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= '0;
        end else if (div_cnt == AIR_DIV_W'(AIR_DIV - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end
    assign air_tick = (div_cnt == AIR_DIV_W'(AIR_DIV - 1));

    // Priority policy, toggled by the configuration menu action
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            txprio <= TXPRIO_RESET;
        end else if (i_txprio_toggle) begin
            txprio <= !txprio;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            threshold <= THRESH_RESET;
        end else if (i_threshold_load) begin
            threshold <= i_threshold;
        end
    end

    // Voltage code to dBm table, 5 dB steps clamped to the span
    for (genvar g = 0; g < 16; g++) begin : g_tab
        localparam int V = -115 + 5 * g;
        assign rssi_tab[g] = 8'(V > -40 ? -40 : V);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rssi <= RSSI_MIN;
        end else begin
            rssi <= rssi_tab[i_rssi_volt];
        end
    end

    assign above = $signed(rssi) > $signed(threshold);
    assign busy  = above || (state == RCAA_RX);

    // Power code clamp by model variant
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_power_code <= 3'h0;
        end else if (i_high_power_model) begin
            o_power_code <= (i_power_code > PWR_MAX_HIGH) ?
                            PWR_MAX_HIGH : i_power_code;
        end else begin
            o_power_code <= (i_power_code > PWR_MAX_STD) ?
                            PWR_MAX_STD : i_power_code;
        end
    end

    // Terminal pause detector
    assign pause_len = PAUSE_W'(PAUSE_CHARS * CHAR_BITS) *
                       PAUSE_W'(i_term_bit_cycles);
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_cnt <= '0;
        end else if (i_term_valid) begin
            idle_cnt <= '0;
        end else if (idle_cnt < pause_len) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end
    assign pause_seen = (idle_cnt >= pause_len);

    assign bufc.wr_valid = i_term_valid;
    assign bufc.wr_data  = i_term_data;
    assign bufc.flush    = 1'b0;
    assign o_term_ready  = bufc.wr_ready;

    // Channel state machine
    always_comb begin
        next_state = state;
        case (state)
            RCAA_IDLE: begin
                if (i_term_valid || !bufc.empty) begin
                    next_state = (txprio || !busy) ? RCAA_TX
                                                   : RCAA_WAIT;
                end else if (above && i_rx_sync) begin
                    next_state = RCAA_RX;
                end
            end
            RCAA_RX: begin
                if (txprio && i_term_valid) begin
                    next_state = RCAA_TX;
                end else if (i_rx_done) begin
                    next_state = RCAA_IDLE;
                end
            end
            RCAA_WAIT: begin
                if (!busy) begin
                    next_state = RCAA_TX;
                end
            end
            RCAA_TX: begin
                if (tx_end) begin
                    next_state = RCAA_IDLE;
                end
            end
            default: next_state = RCAA_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= RCAA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign tx_end = bufc.empty && !shifting && pause_seen &&
                    !i_term_valid;

    // Air serialiser: start bit, eight data bits LSB first, stop bit
    assign bufc.rd_ready = (state == RCAA_TX) && !shifting && air_tick;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shifting <= 1'b0;
            shreg    <= 10'h3FF;
            bit_idx  <= 4'h0;
        end else if (air_tick) begin
            if (bufc.rd_ready && bufc.rd_valid) begin
                shifting <= 1'b1;
                shreg    <= {1'b1, bufc.rd_data, 1'b0};
                bit_idx  <= 4'h0;
            end else if (shifting) begin
                shreg   <= {1'b1, shreg[9:1]};
                bit_idx <= bit_idx + 1'b1;
                if (bit_idx == 4'h9) begin
                    shifting <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_on     <= 1'b0;
            o_rx_search <= 1'b0;
            o_rx_abort  <= 1'b0;
            o_carrier_present_indicator <= 1'b0;
        end else begin
            o_tx_on     <= (next_state == RCAA_TX);
            o_rx_search <= above && (next_state != RCAA_TX);
            o_rx_abort  <= (state == RCAA_RX) &&
                           (next_state == RCAA_TX);
            o_carrier_present_indicator <= above;
        end
    end

    assign o_tx_bit   = shifting ? shreg[0] : 1'b1;
    assign o_rssi_dbm = rssi;
    assign o_txprio   = txprio;
    assign o_state    = state;

    property p_prio_reset;
        @(posedge i_sys_clk) $rose(i_rst_n) |-> txprio;
    endproperty
    a_prio_reset: assert property (p_prio_reset)
        else $error("priority not enabled after reset");

    property p_tx_immediate;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (txprio && state == RCAA_IDLE && i_term_valid) |=> o_tx_on;
    endproperty
    a_tx_immediate: assert property (p_tx_immediate)
        else $error("transmitter not keyed on terminal data");

    sequence s_rx_hit;
        state == RCAA_RX && txprio && i_term_valid;
    endsequence
    property p_rx_abort;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_rx_hit |=> (state == RCAA_TX) && o_rx_abort;
    endproperty
    a_rx_abort: assert property (p_rx_abort)
        else $error("reception not abandoned for transmit");

    property p_defer;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!txprio && busy && state != RCAA_TX) |=> state != RCAA_TX;
    endproperty
    a_defer: assert property (p_defer)
        else $error("transmit started on busy channel");

    property p_search_gate;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_rx_search |-> $past(above);
    endproperty
    a_search_gate: assert property (p_search_gate)
        else $error("search active below threshold");

    property p_power;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_high_power_model |=> o_power_code <= PWR_MAX_STD;
    endproperty
    a_power: assert property (p_power)
        else $error("high power code on standard model");

    property p_rssi_span;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $signed(rssi) >= $signed(RSSI_MIN) &&
        $signed(rssi) <= $signed(RSSI_MAX);
    endproperty
    a_rssi_span: assert property (p_rssi_span)
        else $error("rssi out of span");

    property p_tx_end;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (state == RCAA_TX && !tx_end) |=> state == RCAA_TX;
    endproperty
    a_tx_end: assert property (p_tx_end)
        else $error("transmission ended early");

    property p_bit_rate;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $changed(o_tx_bit) && shifting |-> $past(air_tick);
    endproperty
    a_bit_rate: assert property (p_bit_rate)
        else $error("air bit changed off the bit tick");

    property p_busy;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (state == RCAA_WAIT) && !above |=> state == RCAA_TX;
    endproperty
    a_busy: assert property (p_busy)
        else $error("deferred transmit held on a free channel");
endmodule : rcaa_arbiter
`default_nettype wire

// ### rcaa_term_model.sv
// Terminal model: offers bytes with valid/ready until a quota is reached.
// Assumes the arbiter samples valid and data on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module rcaa_term_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_quota,
    input  wire logic       i_ready,
    output logic      [7:0] o_data,
    output logic            o_valid,
    output logic      [7:0] o_sent
);
    logic [7:0] next_sent;
    assign next_sent = o_sent + {7'h00, o_valid};
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= 8'hA5;
            o_valid <= 1'b0;
            o_sent <= 8'h00;
        end else if (!(o_valid && !i_ready)) begin
            // Data keeps changing while no byte is offered
            o_sent <= next_sent;
            o_valid <= next_sent != i_quota;
            o_data <= {o_data[6:0], o_data[7]} ^ 8'h3B;
        end
    end
endmodule : rcaa_term_model
`default_nettype wire

// ### rcaa_arbiter_tb_top.sv
// Self-checking bench for the arbiter with a terminal model in front.
// Assumes the air bit period is AIR_DIV cycles and frames are 8N1.
`timescale 1ns/1ns
`default_nettype none
module rcaa_arbiter_tb_top;
    import rcaa_pkg::*;
    logic        i_sys_clk, i_rst_n, i_txprio_toggle, i_high_power_model;
    logic        i_threshold_load, i_rx_sync, i_rx_done;
    logic [15:0] i_term_bit_cycles;
    logic [7:0]  i_threshold, quota, t_data, t_sent;
    logic [3:0]  i_rssi_volt;
    logic [2:0]  i_power_code;
    logic        t_valid, o_term_ready, o_tx_on, o_tx_bit, o_rx_search;
    logic        o_rx_abort, o_carrier_present_indicator, o_txprio;
    logic [2:0]  o_power_code;
    logic [7:0]  o_rssi_dbm;
    logic [1:0]  o_state;
    logic [31:0] seed = 32'h38;
    logic [7:0]  sent_q[$];
    int          failures, check_count, cycles;

    rcaa_arbiter rcaa_arbiter_inst (.i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n), .i_term_data(t_data), .i_term_valid(t_valid),
        .o_term_ready(o_term_ready), .i_term_bit_cycles(i_term_bit_cycles),
        .i_txprio_toggle(i_txprio_toggle),
        .i_high_power_model(i_high_power_model),
        .i_power_code(i_power_code), .i_threshold(i_threshold),
        .i_threshold_load(i_threshold_load), .i_rssi_volt(i_rssi_volt),
        .i_rx_sync(i_rx_sync), .i_rx_done(i_rx_done), .o_tx_on(o_tx_on),
        .o_tx_bit(o_tx_bit), .o_rx_search(o_rx_search),
        .o_rx_abort(o_rx_abort), .o_power_code(o_power_code),
        .o_rssi_dbm(o_rssi_dbm),
        .o_carrier_present_indicator(o_carrier_present_indicator),
        .o_txprio(o_txprio), .o_state(o_state));
    rcaa_term_model rcaa_term_model_inst (.i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n), .i_quota(quota), .i_ready(o_term_ready),
        .o_data(t_data), .o_valid(t_valid), .o_sent(t_sent));

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        if (i_rst_n && t_valid && o_term_ready) sent_q.push_back(t_data);
        cycles++;
        if (cycles == 95000) begin
            failures++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic clk(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : clk
    task automatic settle();
        @(negedge i_sys_clk);
    endtask : settle
    task automatic wait_on(input logic want, input int lim);
        int k;
        k = 0;
        while (o_tx_on !== want && k < lim) begin
            settle();
            k++;
        end
        check(o_tx_on, want);
    endtask : wait_on
    // Decodes one air frame at the fixed air bit period
    task automatic air_byte();
        int k;
        logic [7:0] b;
        k = 0;
        while (o_tx_bit !== 1'b0 && k < 6000) begin
            settle();
            k++;
        end
        repeat (AIR_DIV / 2) settle();
        check(o_tx_bit, 0);
        for (int i = 0; i < 8; i++) begin
            repeat (AIR_DIV) settle();
            b[i] = o_tx_bit;
        end
        repeat (AIR_DIV) settle();
        check(o_tx_bit, 1);
        check(b, sent_q.pop_front());
    endtask : air_byte
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        int c, thr, e;
        logic ab, on;
        {i_txprio_toggle, i_high_power_model, i_threshold_load} = 3'h0;
        {i_rx_sync, i_rx_done, i_rst_n, i_power_code} = 6'h00;
        {i_rssi_volt, quota} = 12'h000;
        i_term_bit_cycles = 16'h0004;
        i_threshold = 8'h8F;
        clk(2);
        i_rst_n <= 1'b1;
        settle();
        check(o_txprio, 1);
        check(o_rssi_dbm, 8'h8D);
        check(o_tx_bit, 1);
        check(o_tx_on, 0);
        $display("test reset done");
        for (int h = 0; h < 2; h++) begin
            for (int p = 0; p < 7; p++) begin
                clk(1);
                i_high_power_model <= h[0];
                i_power_code <= p[2:0];
                clk(3);
                settle();
                c = (p > (h ? 6 : 4)) ? (h ? 6 : 4) : p;
                check(o_power_code, c);
            end
        end
        $display("test power done");
        for (int n = 0; n < 13; n++) begin
            c = int'(rnd() % 16);
            thr = (n == 12) ? -113 : -115 + int'(rnd() % 80);
            clk(1);
            i_threshold <= thr[7:0];
            i_threshold_load <= 1'b1;
            i_rssi_volt <= c[3:0];
            clk(1);
            i_threshold_load <= 1'b0;
            clk(3);
            settle();
            e = (-115 + 5 * c > -40) ? -40 : -115 + 5 * c;
            check(o_rssi_dbm, e[7:0]);
            check(o_carrier_present_indicator, e > thr);
            check(o_rx_search, e > thr);
        end
        $display("test rssi done");
        clk(1);
        i_rssi_volt <= 4'hA;
        i_rx_sync <= 1'b1;
        clk(3);
        settle();
        check(o_state, 1);
        clk(1);
        quota <= 8'h02;
        {ab, on} = 2'b00;
        repeat (6) begin
            settle();
            ab |= o_rx_abort;
            on |= o_tx_on;
        end
        check(ab, 1);
        check(on, 1);
        check(o_state, 3);
        clk(1);
        i_rx_sync <= 1'b0;
        i_rx_done <= 1'b1;
        i_rssi_volt <= 4'h0;
        clk(1);
        i_rx_done <= 1'b0;
        air_byte();
        air_byte();
        wait_on(1'b0, 3000);
        $display("test priority on done");
        clk(1);
        i_txprio_toggle <= 1'b1;
        i_rssi_volt <= 4'hA;
        clk(1);
        i_txprio_toggle <= 1'b0;
        quota <= 8'h03;
        clk(200);
        settle();
        check(o_txprio, 0);
        check(o_tx_on, 0);
        check(o_state, 2);
        clk(1);
        i_rssi_volt <= 4'h0;
        wait_on(1'b1, 10);
        air_byte();
        wait_on(1'b0, 3000);
        $display("test priority off done");
        clk(1);
        i_rssi_volt <= 4'hA;
        quota <= 8'h49;
        clk(300);
        settle();
        // Three earlier bytes, a full array and the registered output word
        check(t_sent, 3 + BUF_DEPTH + 1);
        check(o_term_ready, 0);
        clk(1);
        i_rst_n <= 1'b0;
        quota <= 8'h00;
        clk(2);
        i_rst_n <= 1'b1;
        settle();
        check(o_term_ready, 1);
        check(o_txprio, 1);
        $display("test buffer fill done");
        report_and_stop();
    end
endmodule : rcaa_arbiter_tb_top
`default_nettype wire
